// *** core/gfp_top.sv ***
// fault pin propagation block: command registers, condition mapping and pin control
`timescale 1ns/1ps
`default_nettype none

// Function
// - two-byte propagation word, read and written by command, bit per condition.
// - pgood0 bit set pulls the pin low while channel 0 power not good.
// - pgood propagation needs ignore response, else the output latches off.
// - a zero propagation bit leaves the fault pin untouched.
// - undertemperature bit maps page faults to their own pins.
// - overtemperature bit maps page faults to their own pins.
// - input overvoltage bit pulls the pin low on input overvoltage.
// - overcurrent bit maps page faults to their own pins.
// - output undervoltage bit maps page faults to their own pins.
// - output overvoltage bit maps page faults to their own pins.
// - paged one-byte response setting at 0xD5, reset value 0xC0.
// - response 0xC0 three-states the output on an external pull-low.
// - response 0x00 keeps regulating while the pin is held low.
// - external pull-low sets byte, word and manufacturer status bits.
// - external pull-low raises alert unless channel config bit 1 set.
module gfp_top #(
  parameter int NUM_PINS = 2,
  parameter logic [15:0] PROP_RESET_VAL = gfp_pkg::PROP_RESET
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [((NUM_PINS > 1) ? $clog2(NUM_PINS) : 1)-1:0] cmd_page,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_wack,
  output logic cmd_err,
  // fault conditions, one per page unless common
  input wire logic [NUM_PINS-1:0] chan_pgood,
  input wire logic [NUM_PINS-1:0] fault_undertemp,
  input wire logic [NUM_PINS-1:0] fault_overtemp,
  input wire logic fault_vin_overvolt,
  input wire logic [NUM_PINS-1:0] fault_overcurrent,
  input wire logic [NUM_PINS-1:0] fault_out_undervolt,
  input wire logic [NUM_PINS-1:0] fault_out_overvolt,
  // control from the rest of the controller
  input wire logic [NUM_PINS-1:0] chan_restart,
  input wire logic clear_faults,
  // shared open-drain fault pins
  input wire logic [NUM_PINS-1:0] fault_pin_in,
  output logic [NUM_PINS-1:0] fault_pin_out,
  output logic [NUM_PINS-1:0] fault_pin_oe,
  // power stage and status
  output logic [NUM_PINS-1:0] power_out_inhibit,
  output logic [NUM_PINS-1:0] status_byte_nota,
  output logic [NUM_PINS-1:0] status_word_mfr,
  output logic [NUM_PINS-1:0] fault_pin_low_status,
  // open-drain alert line
  output logic alert_out,
  output logic alert_oe
);

  // ==========================================================================
  // sizes
  // ==========================================================================
  localparam int PAGE_W = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [NUM_PINS-1:0][15:0] prop_cfg;
    logic [NUM_PINS-1:0][7:0] response;
    logic [NUM_PINS-1:0][7:0] chan_cfg;
    logic [15:0] rdata;
    logic rvalid;
    logic wack;
    logic err;
    logic alert_oe;
    logic alert_lvl;
    logic [NUM_PINS-1:0] pin_out;
  } gfp_top_regs_t;

  // response resets to inhibit on every page
  localparam gfp_top_regs_t RESET_STATE = '{
    prop_cfg: {NUM_PINS{PROP_RESET_VAL & gfp_pkg::PROP_WRITE_MASK}},
    response: {NUM_PINS{gfp_pkg::RESP_RESET}},
    chan_cfg: {NUM_PINS{gfp_pkg::CHCFG_RESET}},
    rdata: 16'h0000,
    rvalid: 1'b0,
    wack: 1'b0,
    err: 1'b0,
    alert_oe: 1'b0,
    alert_lvl: 1'b0,
    pin_out: '0
  };

  gfp_top_regs_t state_q;
  gfp_top_regs_t state_d;

  // per-pin signals
  logic [NUM_PINS-1:0] pull_req;
  logic [NUM_PINS-1:0] pin_oe_w;
  logic [NUM_PINS-1:0] inhibit_w;
  logic [NUM_PINS-1:0] nota_w;
  logic [NUM_PINS-1:0] mfr_w;
  logic [NUM_PINS-1:0] pin_low_w;
  logic [NUM_PINS-1:0] alert_w;
  logic page_ok;
  logic code_ok;

  // ==========================================================================
  // decoding helpers
  // ==========================================================================

  // commands this block answers; anything else is refused
  function automatic logic gfp_cmd_known(input logic [7:0] code);
    return (code == gfp_pkg::CMD_PIN_RESPONSE) ||
           (code == gfp_pkg::CMD_PROPAGATE_CFG) ||
           (code == gfp_pkg::CMD_CHANNEL_CONFIG) ||
           (code == gfp_pkg::CMD_PIN_STATUS);
  endfunction : gfp_cmd_known

  // one pin's pull request from its page's propagation word
  function automatic logic gfp_pull_needed(
    input logic [15:0] cfg,
    input logic pgood0,
    input logic ut,
    input logic ot,
    input logic vin_ov,
    input logic oc,
    input logic uv,
    input logic ov
  );
    logic any;
    any = 1'b0;
    any = any | (cfg[gfp_pkg::PROP_PGOOD0_BIT] & ~pgood0);
    any = any | (cfg[gfp_pkg::PROP_UT_BIT] & ut);
    any = any | (cfg[gfp_pkg::PROP_OT_BIT] & ot);
    any = any | (cfg[gfp_pkg::PROP_VIN_OV_BIT] & vin_ov);
    any = any | (cfg[gfp_pkg::PROP_IOUT_OC_BIT] & oc);
    any = any | (cfg[gfp_pkg::PROP_VOUT_UV_BIT] & uv);
    any = any | (cfg[gfp_pkg::PROP_VOUT_OV_BIT] & ov);
    return any;
  endfunction : gfp_pull_needed

  // ==========================================================================
  // command acceptance
  // ==========================================================================

  // pages beyond the pin count are refused rather than aliased
  assign page_ok = (32'(cmd_page) < NUM_PINS);
  assign code_ok = gfp_cmd_known(cmd_code);

  // ==========================================================================
  // register file and read path
  // ==========================================================================

  // a write wins over a read presented in the same cycle
  always_comb begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    state_d.wack = 1'b0;
    state_d.err = 1'b0;
    state_d.pin_out = '0;
    // the alert line is open-drain too, so its data level stays low
    state_d.alert_lvl = 1'b0;
    if (cmd_wr) begin
      // status is read-only, so a write to it is refused too
      if (!code_ok || !page_ok || cmd_code == gfp_pkg::CMD_PIN_STATUS) begin
        state_d.err = 1'b1;
      end else begin
        state_d.wack = 1'b1;
        unique case (cmd_code)
          gfp_pkg::CMD_PROPAGATE_CFG: begin
            state_d.prop_cfg[cmd_page] = cmd_wdata & gfp_pkg::PROP_WRITE_MASK;
          end
          gfp_pkg::CMD_PIN_RESPONSE: begin
            state_d.response[cmd_page] = cmd_wdata[7:0];
          end
          default: begin
            state_d.chan_cfg[cmd_page] = cmd_wdata[7:0];
          end
        endcase
      end
    end else if (cmd_rd) begin
      if (!code_ok || !page_ok) begin
        state_d.err = 1'b1;
      end else begin
        state_d.rvalid = 1'b1;
        unique case (cmd_code)
          gfp_pkg::CMD_PROPAGATE_CFG: begin
            state_d.rdata = state_q.prop_cfg[cmd_page];
          end
          gfp_pkg::CMD_PIN_RESPONSE: begin
            state_d.rdata = {8'h00, state_q.response[cmd_page]};
          end
          gfp_pkg::CMD_CHANNEL_CONFIG: begin
            state_d.rdata = {8'h00, state_q.chan_cfg[cmd_page]};
          end
          default: begin
            // live view of the pin's own state
            state_d.rdata = 16'h0000;
            state_d.rdata[gfp_pkg::STAT_NOTA_BIT] = nota_w[cmd_page];
            state_d.rdata[gfp_pkg::STAT_MFR_BIT] = mfr_w[cmd_page];
            state_d.rdata[gfp_pkg::STAT_PIN_LOW_BIT] = pin_low_w[cmd_page];
            state_d.rdata[gfp_pkg::STAT_ALERT_BIT] = alert_w[cmd_page];
            state_d.rdata[gfp_pkg::STAT_INHIBIT_BIT] = inhibit_w[cmd_page];
            state_d.rdata[gfp_pkg::STAT_DRIVE_BIT] = pin_oe_w[cmd_page];
          end
        endcase
      end
    end
    // one shared alert line for all pins
    state_d.alert_oe = |alert_w;
  end

  // single register stage for all top-level state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // per-pin logic
  // ==========================================================================

  // channel 0 power good feeds every page, as the word defines it
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    // OR of enabled conditions for this page
    assign pull_req[p] = gfp_pull_needed(
      state_q.prop_cfg[p],
      chan_pgood[0],
      fault_undertemp[p],
      fault_overtemp[p],
      fault_vin_overvolt,
      fault_overcurrent[p],
      fault_out_undervolt[p],
      fault_out_overvolt[p]
    );

    gfp_pin_ctrl u_pin (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pull_req(pull_req[p]),
      .pin_in(fault_pin_in[p]),
      .response(state_q.response[p]),
      .alert_disable(state_q.chan_cfg[p][gfp_pkg::CHCFG_ALERT_DIS_BIT]),
      .restart(chan_restart[p]),
      .clear_faults(clear_faults),
      .pin_oe(pin_oe_w[p]),
      .out_inhibit(inhibit_w[p]),
      .stat_nota(nota_w[p]),
      .stat_mfr(mfr_w[p]),
      .stat_pin_low(pin_low_w[p]),
      .alert_req(alert_w[p])
    );
  end

  // ==========================================================================
  // outputs
  // ==========================================================================

  // command answers
  assign cmd_rdata = state_q.rdata;
  assign cmd_rvalid = state_q.rvalid;
  assign cmd_wack = state_q.wack;
  assign cmd_err = state_q.err;

  // open-drain pins only ever drive low; the enable carries the fault
  assign fault_pin_out = state_q.pin_out;
  assign fault_pin_oe = pin_oe_w;

  // pin-side state, each from a flop inside the pin controller
  assign power_out_inhibit = inhibit_w;
  assign status_byte_nota = nota_w;
  assign status_word_mfr = mfr_w;
  assign fault_pin_low_status = pin_low_w;

  // alert trails the pin flags by one cycle, a harmless lag for software
  assign alert_out = state_q.alert_lvl;
  assign alert_oe = state_q.alert_oe;

endmodule : gfp_top

`default_nettype wire

// *** core/gfp_pkg.sv ***
// shared constants and types for the fault pin propagation block
package gfp_pkg;

  // ==========================================================================
  // command codes
  // ==========================================================================
  localparam logic [7:0] CMD_PIN_RESPONSE = 8'hD5;
  localparam logic [7:0] CMD_PROPAGATE_CFG = 8'hD2;
  localparam logic [7:0] CMD_CHANNEL_CONFIG = 8'hD0;
  localparam logic [7:0] CMD_PIN_STATUS = 8'hD3;

  // ==========================================================================
  // fault pin response values and reset values
  // ==========================================================================
  localparam logic [7:0] RESP_INHIBIT = 8'hC0;
  localparam logic [7:0] RESP_IGNORE = 8'h00;
  localparam logic [7:0] RESP_RESET = 8'hC0;
  localparam logic [15:0] PROP_RESET = 16'h0000;
  localparam logic [7:0] CHCFG_RESET = 8'h00;

  // ==========================================================================
  // propagation word field positions
  // ==========================================================================
  localparam int PROP_VOUT_OV_BIT = 0;
  localparam int PROP_VOUT_UV_BIT = 1;
  localparam int PROP_IOUT_OC_BIT = 2;
  localparam int PROP_VIN_OV_BIT = 4;
  localparam int PROP_OT_BIT = 7;
  localparam int PROP_UT_BIT = 8;
  localparam int PROP_PGOOD0_BIT = 9;
  // only implemented bits take writes; reserved and upper bits read zero
  localparam logic [15:0] PROP_WRITE_MASK = 16'h0397;

  // ==========================================================================
  // channel config and status read layout
  // ==========================================================================
  localparam int CHCFG_ALERT_DIS_BIT = 1;
  localparam int STAT_NOTA_BIT = 0;
  localparam int STAT_MFR_BIT = 1;
  localparam int STAT_PIN_LOW_BIT = 2;
  localparam int STAT_ALERT_BIT = 3;
  localparam int STAT_INHIBIT_BIT = 4;
  localparam int STAT_DRIVE_BIT = 5;

  // ==========================================================================
  // per-pin power stage mode
  // ==========================================================================
  typedef enum logic {
    PIN_RUN,
    PIN_INHIBITED
  } gfp_pin_state_t;

endpackage : gfp_pkg

// *** core/gfp_pin_ctrl.sv ***
// one fault pin: open-drain drive, inhibit response, sticky status and alert request
`timescale 1ns/1ps
`default_nettype none

module gfp_pin_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pull_req,
  input wire logic pin_in,
  input wire logic [7:0] response,
  input wire logic alert_disable,
  input wire logic restart,
  input wire logic clear_faults,
  output logic pin_oe,
  output logic out_inhibit,
  output logic stat_nota,
  output logic stat_mfr,
  output logic stat_pin_low,
  output logic alert_req
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic drive;
    gfp_pkg::gfp_pin_state_t mode;
    logic nota;
    logic mfr;
    logic pin_low;
    logic alert;
  } gfp_pin_regs_t;

  gfp_pin_regs_t state_q;
  gfp_pin_regs_t state_d;
  logic ext_low;
  logic resp_inhibit;

  // a low pin only counts as external while we are not pulling it ourselves
  assign ext_low = ~pin_in & ~state_q.drive;
  assign resp_inhibit = (response == gfp_pkg::RESP_INHIBIT);

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    // pull low while any enabled condition
    state_d.drive = pull_req;
    unique case (state_q.mode)
      gfp_pkg::PIN_RUN: begin
        // own pull also inhibits, hence latch-off
        if (!pin_in && resp_inhibit) begin
          state_d.mode = gfp_pkg::PIN_INHIBITED;
        end
      end
      gfp_pkg::PIN_INHIBITED: begin
        if (restart && pin_in) begin
          state_d.mode = gfp_pkg::PIN_RUN;
        end
      end
    endcase
    // sticky flags: a set in the clearing cycle wins
    if (clear_faults) begin
      state_d.nota = 1'b0;
      state_d.mfr = 1'b0;
      state_d.pin_low = 1'b0;
      state_d.alert = 1'b0;
    end
    if (ext_low) begin
      state_d.nota = 1'b1;
      state_d.mfr = 1'b1;
      state_d.pin_low = 1'b1;
    end
    if (ext_low && !alert_disable) begin
      state_d.alert = 1'b1;
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs come straight from the state flops
  assign pin_oe = state_q.drive;
  assign out_inhibit = (state_q.mode == gfp_pkg::PIN_INHIBITED);
  assign stat_nota = state_q.nota;
  assign stat_mfr = state_q.mfr;
  assign stat_pin_low = state_q.pin_low;
  assign alert_req = state_q.alert;

endmodule : gfp_pin_ctrl

`default_nettype wire

// *** tb/gfp_checker.sv ***
// concurrent checks on the fault pin propagation block ports
`timescale 1ns/1ps
`default_nettype none

module gfp_checker #(
  parameter int NUM_PINS = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_wack,
  input wire logic cmd_err,
  input wire logic [NUM_PINS-1:0] chan_pgood,
  input wire logic [NUM_PINS-1:0] fault_undertemp,
  input wire logic [NUM_PINS-1:0] fault_overtemp,
  input wire logic fault_vin_overvolt,
  input wire logic [NUM_PINS-1:0] fault_overcurrent,
  input wire logic [NUM_PINS-1:0] fault_out_undervolt,
  input wire logic [NUM_PINS-1:0] fault_out_overvolt,
  input wire logic [NUM_PINS-1:0] chan_restart,
  input wire logic clear_faults,
  input wire logic [NUM_PINS-1:0] fault_pin_in,
  input wire logic [NUM_PINS-1:0] fault_pin_oe,
  input wire logic [NUM_PINS-1:0] power_out_inhibit,
  input wire logic [NUM_PINS-1:0] status_byte_nota,
  input wire logic [NUM_PINS-1:0] status_word_mfr,
  input wire logic [NUM_PINS-1:0] fault_pin_low_status,
  input wire logic alert_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // upper bound of what may pull each pin; config is not visible here
  wire logic [NUM_PINS-1:0] cond;
  assign cond = fault_undertemp | fault_overtemp | fault_overcurrent | fault_out_undervolt |
    fault_out_overvolt | {NUM_PINS{fault_vin_overvolt | !chan_pgood[0]}};

  // ==========================================================================
  // sequences
  // ==========================================================================
  sequence s_ext0;
    !fault_pin_in[0] && !fault_pin_oe[0];
  endsequence
  sequence s_status_then_alert;
    (|fault_pin_low_status) ##1 $rose(alert_oe);
  endsequence

  // ==========================================================================
  // assertions
  // ==========================================================================
  a_idle_pin0_free: assert property (!cond[0] |=> !fault_pin_oe[0])
    else $error("pin 0 driven with no condition");
  a_idle_pin1_free: assert property (!cond[1] |=> !fault_pin_oe[1])
    else $error("pin 1 driven with no condition");
  a_ext_status_set: assert property (s_ext0 |=> status_byte_nota[0] && status_word_mfr[0]
    && fault_pin_low_status[0])
    else $error("external pull-low did not set status");
  a_status_stays_set: assert property (status_word_mfr[0] && !clear_faults |=> status_word_mfr[0])
    else $error("status dropped without clear");
  a_alert_has_cause: assert property ($rose(alert_oe) |-> $past(|fault_pin_low_status))
    else $error("alert raised without pin status");
  a_resp_write_ack: assert property (cmd_wr && cmd_code == gfp_pkg::CMD_PIN_RESPONSE
    |=> cmd_wack && !cmd_err)
    else $error("response write not accepted");
  a_reserved_read_zero: assert property (cmd_rd && !cmd_wr && cmd_code == gfp_pkg::CMD_PROPAGATE_CFG
    |=> (cmd_rdata & 16'hFC68) == 16'h0000)
    else $error("reserved propagation bits read nonzero");
  a_inhibit_cause: assert property ($rose(power_out_inhibit[0]) |-> $past(!fault_pin_in[0]))
    else $error("inhibit without low pin");
  a_inhibit_held: assert property (power_out_inhibit[0] && !(chan_restart[0] && fault_pin_in[0])
    |=> power_out_inhibit[0])
    else $error("inhibit released early");
  c_alert_seen: cover property (s_status_then_alert);
endmodule : gfp_checker

`default_nettype wire

// *** tb/gfp_peer_model.sv ***
// another controller on the shared fault wires, pulling them low on request
`timescale 1ns/1ps
`default_nettype none

module gfp_peer_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] pull_req,
  output logic [1:0] pull_oe
);
  // registered like a real controller: the pull lands one edge late
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_oe <= 2'h0;
    end else begin
      pull_oe <= pull_req;
    end
  end
endmodule : gfp_peer_model

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the fault pin propagation block
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [2:0] sel;
    logic fp;
    logic [1:0] oe;
  } gfp_row_t;

  logic core_clk, rst_n, cmd_wr, cmd_rd, clear_faults, fault_vin_overvolt;
  logic [7:0] cmd_code;
  logic [0:0] cmd_page;
  logic [15:0] cmd_wdata, cmd_rdata;
  logic cmd_rvalid, cmd_wack, cmd_err, alert_out, alert_oe;
  logic [1:0] chan_pgood, fault_undertemp, fault_overtemp, fault_overcurrent;
  logic [1:0] fault_out_undervolt, fault_out_overvolt, chan_restart, peer_req, peer_oe;
  logic [1:0] fault_pin_out, fault_pin_oe, power_out_inhibit;
  logic [1:0] status_byte_nota, status_word_mfr, fault_pin_low_status;
  wire logic [1:0] fault_pin_in;
  int n_mismatch, checked, cycles;

  // wired-low lines with pull-up
  assign fault_pin_in = ~(fault_pin_oe | peer_oe);

  gfp_top dut (.core_clk, .rst_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_page, .cmd_wdata, .cmd_rdata,
    .cmd_rvalid, .cmd_wack, .cmd_err, .chan_pgood, .fault_undertemp, .fault_overtemp, .fault_vin_overvolt,
    .fault_overcurrent, .fault_out_undervolt, .fault_out_overvolt, .chan_restart, .clear_faults,
    .fault_pin_in, .fault_pin_out, .fault_pin_oe, .power_out_inhibit, .status_byte_nota,
    .status_word_mfr, .fault_pin_low_status, .alert_out, .alert_oe);
  gfp_peer_model peer (.core_clk, .rst_n, .pull_req(peer_req), .pull_oe(peer_oe));

  // rows: page 0 word, page 1 word, condition, its page, expected drive
  gfp_row_t rows [11] = '{
    '{16'h0001, 16'h0000, 3'h0, 1'b0, 2'b01},
    '{16'h0000, 16'h0001, 3'h0, 1'b0, 2'b00},
    '{16'h0000, 16'h0002, 3'h1, 1'b1, 2'b10},
    '{16'h0004, 16'h0000, 3'h2, 1'b0, 2'b01},
    '{16'h0010, 16'h0010, 3'h3, 1'b0, 2'b11},
    '{16'h0080, 16'h0000, 3'h4, 1'b1, 2'b00},
    '{16'h0000, 16'h0080, 3'h4, 1'b1, 2'b10},
    '{16'h0100, 16'h0000, 3'h5, 1'b0, 2'b01},
    '{16'h0200, 16'h0000, 3'h6, 1'b0, 2'b01},
    '{16'h0397, 16'h0000, 3'h0, 1'b0, 2'b01},
    '{16'h0396, 16'h0000, 3'h0, 1'b0, 2'b00}
  };

  // 100 ns period
  always #50 core_clk = ~core_clk;

  // hang guard, far above the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_n

  // one command, held for exactly one taking edge, answer awaited a bounded time
  task automatic cmd(input logic w, input logic [7:0] c, input logic p, input logic [15:0] d,
                     output logic [15:0] r, output logic e);
    int i;
    r = 16'hXXXX;
    e = 1'bx;
    @(posedge core_clk);
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_code <= c;
    cmd_page <= p;
    cmd_wdata <= d;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    for (i = 0; i < 3; i++) begin
      #1;
      if (cmd_wack === 1'b1 || cmd_rvalid === 1'b1 || cmd_err === 1'b1) begin
        r = cmd_rdata;
        e = cmd_err;
        i = 9;
      end else begin
        @(posedge core_clk);
      end
    end
  endtask : cmd

  task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] d, input logic exp_err);
    logic [15:0] r;
    logic e;
    cmd(1'b1, c, p, d, r, e);
    chk(e, exp_err);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] exp);
    logic [15:0] r;
    logic e;
    cmd(1'b0, c, p, 16'h0000, r, e);
    chk(r, exp);
  endtask : rd

  task automatic set_fault(input logic [2:0] sel, input logic fp, input logic v);
    @(posedge core_clk);
    case (sel)
      3'h0: fault_out_overvolt[fp] <= v;
      3'h1: fault_out_undervolt[fp] <= v;
      3'h2: fault_overcurrent[fp] <= v;
      3'h3: fault_vin_overvolt <= v;
      3'h4: fault_overtemp[fp] <= v;
      3'h5: fault_undertemp[fp] <= v;
      default: chan_pgood[0] <= !v;
    endcase
  endtask : set_fault

  // main sequence
  initial begin
    {core_clk, rst_n, cmd_wr, cmd_rd, clear_faults, fault_vin_overvolt, cmd_page} = '0;
    {cmd_code, cmd_wdata, fault_undertemp, fault_overtemp, fault_overcurrent} = '0;
    {fault_out_undervolt, fault_out_overvolt, chan_restart, peer_req} = '0;
    chan_pgood = 2'h3;
    {n_mismatch, checked, cycles} = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // ignore response first, so power-good propagation cannot latch off
    // host programs ignore
    wr(gfp_pkg::CMD_PIN_RESPONSE, 1'b0, 16'h0000, 1'b0);
    wr(gfp_pkg::CMD_PIN_RESPONSE, 1'b1, 16'h0000, 1'b0);
    foreach (rows[k]) begin
      wr(gfp_pkg::CMD_PROPAGATE_CFG, 1'b0, rows[k].w0, 1'b0);
      wr(gfp_pkg::CMD_PROPAGATE_CFG, 1'b1, rows[k].w1, 1'b0);
      set_fault(rows[k].sel, rows[k].fp, 1'b1);
      wait_n(3);
      chk(fault_pin_oe, rows[k].oe);
      chk({fault_pin_out, alert_out}, 3'h0);
      chk(power_out_inhibit, 2'h0);
      set_fault(rows[k].sel, rows[k].fp, 1'b0);
      wait_n(3);
      chk(fault_pin_oe, 2'h0);
    end
    // reserved bits and refused commands
    wr(gfp_pkg::CMD_PROPAGATE_CFG, 1'b1, 16'hFFFF, 1'b0);
    rd(gfp_pkg::CMD_PROPAGATE_CFG, 1'b1, 16'h0397);
    wr(gfp_pkg::CMD_PIN_STATUS, 1'b0, 16'h00FF, 1'b1);
    wr(8'h55, 1'b0, 16'h0000, 1'b1);
    // reset in mid-run restores defaults
    @(posedge core_clk);
    rst_n <= 1'b0;
    wait_n(3);
    chk({fault_pin_oe, power_out_inhibit, alert_oe}, 16'h0000);
    @(posedge core_clk);
    rst_n <= 1'b1;
    rd(gfp_pkg::CMD_PIN_RESPONSE, 1'b0, 16'h00C0);
    rd(gfp_pkg::CMD_PIN_RESPONSE, 1'b1, 16'h00C0);
    rd(gfp_pkg::CMD_PROPAGATE_CFG, 1'b1, 16'h0000);
    // pin 0 pulled by the peer, inhibit response
    @(posedge core_clk);
    peer_req <= 2'b01;
    wait_n(4);
    chk(power_out_inhibit, 2'b01);
    chk({status_byte_nota[0], status_word_mfr[0], fault_pin_low_status[0]}, 3'h7);
    chk(alert_oe, 1'b1);
    // live status word: nota, mfr, pin low, alert, inhibit set; own drive off
    rd(gfp_pkg::CMD_PIN_STATUS, 1'b0, 16'h001F);
    @(posedge core_clk);
    peer_req <= 2'b00;
    chan_restart[0] <= 1'b1;
    wait_n(3);
    chk(power_out_inhibit, 2'b00);
    @(posedge core_clk);
    chan_restart[0] <= 1'b0;
    clear_faults <= 1'b1;
    @(posedge core_clk);
    clear_faults <= 1'b0;
    wait_n(3);
    chk({alert_oe, status_word_mfr}, 3'h0);
    // pin 1 pulled, ignore response and alert masked
    wr(gfp_pkg::CMD_PIN_RESPONSE, 1'b1, 16'h0000, 1'b0);
    wr(gfp_pkg::CMD_CHANNEL_CONFIG, 1'b1, 16'h0002, 1'b0);
    @(posedge core_clk);
    peer_req <= 2'b10;
    wait_n(4);
    chk(power_out_inhibit, 2'b00);
    chk({status_byte_nota, status_word_mfr, fault_pin_low_status}, 6'h2A);
    chk(alert_oe, 1'b0);
    @(posedge core_clk);
    peer_req <= 2'b00;
    wait_n(2);
    test_done();
  end
endmodule : tb

bind gfp_top gfp_checker #(.NUM_PINS(NUM_PINS)) u_chk (.core_clk, .rst_n, .cmd_wr, .cmd_rd, .cmd_code,
  .cmd_rdata, .cmd_wack, .cmd_err, .chan_pgood, .fault_undertemp, .fault_overtemp, .fault_vin_overvolt,
  .fault_overcurrent, .fault_out_undervolt, .fault_out_overvolt, .chan_restart, .clear_faults,
  .fault_pin_in, .fault_pin_oe, .power_out_inhibit, .status_byte_nota, .status_word_mfr,
  .fault_pin_low_status, .alert_oe);

`default_nettype wire
